// file: core/fsapg_top.sv
// Flash self-program access guard: permission, stall and busy logic
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Store-program from the application region is ignored.
// - Store-program from boot region may target any page, boot included.
// - Boot size fuses split application and boot; each has own locks.
// - A fixed boundary splits concurrent-read and stall regions.
// - Programming a concurrent-read page keeps the core running.
// - Programming a stall-region page halts the core for the whole cycle.
// - Concurrent-read region is blocked and busy flag set while programming a concurrent-read page.
// - Every boot size keeps the boot region inside the stall region.
// - Lock bits only program; chip erase alone returns them to one.
// - General memory lock never restricts core load or store operations.
// - App lower lock programmed refuses stores into application region.
// - App upper lock programmed refuses boot-executed loads of application.
// - App upper lock with boot vectors masks interrupts in application.
// - Boot lower lock programmed refuses stores into boot region.
// - Boot upper lock programmed refuses application-executed loads of boot.
// - Boot upper lock with application vectors masks interrupts in boot.
// - Both lock bits unprogrammed place no restriction on that region.
// - Busy flag clears on read-enable with store enable, or on buffer load.
module fsapg_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [fsapg_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [fsapg_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [fsapg_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [fsapg_pkg::FUSE_W-1:0] boot_size_fuses,
   input wire logic chip_erase,
   input wire logic ext_lock_wr,
   input wire logic [fsapg_pkg::LOCK_W-1:0] ext_lock_data,
   input wire logic [fsapg_pkg::ADDR_W-1:0] core_pc,
   input wire logic ivec_in_boot,
   input wire logic spm_req,
   input wire fsapg_pkg::fsapg_op_t spm_op,
   input wire logic [fsapg_pkg::ADDR_W-1:0] spm_addr,
   input wire logic [fsapg_pkg::LOCK_W-1:0] spm_lock_data,
   input wire logic lpm_req,
   input wire logic [fsapg_pkg::ADDR_W-1:0] lpm_addr,
   input wire logic prog_done,
   output logic spm_accept,
   output logic spm_refused,
   output logic prog_start,
   output logic prog_erase,
   output logic [fsapg_pkg::ADDR_W-1:0] prog_page,
   output logic core_stall,
   output logic region_busy_flag,
   output logic lpm_grant,
   output logic lpm_deny,
   output logic irq_block
);
   typedef enum logic [1:0] {FSAPG_IDLE, FSAPG_PROG_RWW, FSAPG_PROG_STALL_REGION} fsapg_state_t;

   fsapg_state_t state_reg;
   fsapg_state_t state_next;
   logic wait_reg;
   logic [fsapg_pkg::DATA_W-1:0] readdata_reg;
   logic [fsapg_pkg::FUSE_W-1:0] fuse_reg;
   logic fuse_valid_reg;
   logic [fsapg_pkg::LOCK_W-1:0] lock_reg;
   logic [fsapg_pkg::LOCK_W-1:0] lock_next;
   logic busy_reg;
   logic busy_next;
   logic core_stall_reg;
   logic spm_accept_reg;
   logic spm_refused_reg;
   logic prog_start_reg;
   logic prog_erase_reg;
   logic [fsapg_pkg::ADDR_W-1:0] prog_page_reg;
   logic lpm_grant_reg;
   logic lpm_deny_reg;
   logic irq_block_reg;
   logic irq_block_next;

   // Region decode for the store and the load path
   logic spm_pc_in_boot;
   logic spm_tgt_boot;
   logic spm_tgt_rww;
   logic spm_store_ok;
   logic lpm_tgt_boot;
   logic lpm_tgt_rww;
   logic lpm_load_ok;

   fsapg_guard u_spm_guard (
      .boot_size(fuse_reg),
      .pc(core_pc),
      .target(spm_addr),
      .lock(lock_reg),
      .pc_in_boot(spm_pc_in_boot),
      .tgt_in_boot(spm_tgt_boot),
      .tgt_in_rww(spm_tgt_rww),
      .store_ok(spm_store_ok),
      .load_ok()
   );

   fsapg_guard u_lpm_guard (
      .boot_size(fuse_reg),
      .pc(core_pc),
      .target(lpm_addr),
      .lock(lock_reg),
      .pc_in_boot(),
      .tgt_in_boot(lpm_tgt_boot),
      .tgt_in_rww(lpm_tgt_rww),
      .store_ok(),
      .load_ok(lpm_load_ok)
   );

   // Bus decode; a write takes effect on the edge where waitrequest is sampled low
   wire logic bus_req = avs_read || avs_write;
   wire logic wr_fire = avs_write && !wait_reg && avs_byteenable[0];
   wire logic wr_ctrl = wr_fire && (avs_address == fsapg_pkg::REG_CTRL);
   wire logic wr_lock = wr_fire && (avs_address == fsapg_pkg::REG_LOCK);
   wire logic ctrl_spe = avs_writedata[fsapg_pkg::CTRL_SPE_BIT];
   wire logic ctrl_rre = avs_writedata[fsapg_pkg::CTRL_RRE_BIT];

   wire logic idle = (state_reg == FSAPG_IDLE);
   wire logic is_prog_op = (spm_op == fsapg_pkg::OP_ERASE) || (spm_op == fsapg_pkg::OP_WRITE);
   // Only boot code may store; flash page ops also need the target's lock
   wire logic spm_ok = idle && spm_pc_in_boot && (!is_prog_op || spm_store_ok);
   wire logic spm_go = spm_req && spm_ok;
   wire logic spm_bad = spm_req && !spm_ok;
   wire logic prog_go = spm_go && is_prog_op;
   wire logic load_go = spm_go && (spm_op == fsapg_pkg::OP_LOAD);
   wire logic lockset_go = spm_go && (spm_op == fsapg_pkg::OP_LOCKSET);

   // Read-enable only counts once the flash is no longer busy
   wire logic busy_clr = load_go || (wr_ctrl && ctrl_spe && ctrl_rre && idle);
   wire logic busy_set = prog_go && spm_tgt_rww;

   // Loads into a blocked concurrent-read region are refused
   wire logic lpm_ok = lpm_load_ok && !(busy_reg && lpm_tgt_rww);

   // Lock bits can only go from one to zero outside a chip erase
   wire logic [fsapg_pkg::LOCK_W-1:0] av_mask = wr_lock ? avs_writedata[fsapg_pkg::LOCK_W-1:0] : fsapg_pkg::LOCK_RESET;
   wire logic [fsapg_pkg::LOCK_W-1:0] ext_mask = ext_lock_wr ? ext_lock_data : fsapg_pkg::LOCK_RESET;
   wire logic [fsapg_pkg::LOCK_W-1:0] core_mask = lockset_go ? spm_lock_data : fsapg_pkg::LOCK_RESET;

   logic [fsapg_pkg::DATA_W-1:0] ctrl_rd;
   logic [fsapg_pkg::DATA_W-1:0] lock_rd;
   logic [fsapg_pkg::DATA_W-1:0] stat_rd;
   logic [fsapg_pkg::DATA_W-1:0] rd_mux;
   assign ctrl_rd = (fsapg_pkg::DATA_W'(!idle) << fsapg_pkg::CTRL_SPE_BIT)
                  | (fsapg_pkg::DATA_W'(busy_reg) << fsapg_pkg::CTRL_BUSY_BIT);
   assign lock_rd = fsapg_pkg::DATA_W'(lock_reg);
   assign stat_rd = (fsapg_pkg::DATA_W'(core_stall_reg) << fsapg_pkg::STAT_STALL_BIT)
                  | (fsapg_pkg::DATA_W'(irq_block_reg) << fsapg_pkg::STAT_IRQB_BIT)
                  | (fsapg_pkg::DATA_W'(fuse_reg) << fsapg_pkg::STAT_FUSE_LSB);
   // Unmapped offsets read as zero
   assign rd_mux = (avs_address == fsapg_pkg::REG_CTRL) ? ctrl_rd :
                   (avs_address == fsapg_pkg::REG_LOCK) ? lock_rd :
                   (avs_address == fsapg_pkg::REG_STAT) ? stat_rd : '0;

   assign lock_next = chip_erase ? fsapg_pkg::LOCK_RESET : (lock_reg & av_mask & ext_mask & core_mask);
   assign busy_next = busy_set || (busy_reg && !busy_clr);
   // Interrupts would vector into a region that may not read the running code
   assign irq_block_next = (!lock_reg[fsapg_pkg::LOCK_APP_HI] && ivec_in_boot && !spm_pc_in_boot)
                        || (!lock_reg[fsapg_pkg::LOCK_BOOT_HI] && !ivec_in_boot && spm_pc_in_boot);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FSAPG_IDLE: begin
            if (prog_go) begin
               state_next = spm_tgt_rww ? FSAPG_PROG_RWW : FSAPG_PROG_STALL_REGION;
            end
         end
         FSAPG_PROG_RWW,
         FSAPG_PROG_STALL_REGION: begin
            if (prog_done) begin
               state_next = FSAPG_IDLE;
            end
         end
         default: begin
            state_next = FSAPG_IDLE;
         end
      endcase
   end

   // Bus slave: one wait cycle, then answer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 1'b1;
         readdata_reg <= '0;
      end else begin
         wait_reg <= !(bus_req && wait_reg);
         if (avs_read && wait_reg) begin
            readdata_reg <= rd_mux;
         end
      end
   end

   // Fuses are static; capture once after reset release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fuse_reg <= fsapg_pkg::FUSE_RESET;
         fuse_valid_reg <= 1'b0;
      end else if (!fuse_valid_reg) begin
         fuse_reg <= boot_size_fuses;
         fuse_valid_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= FSAPG_IDLE;
         lock_reg <= fsapg_pkg::LOCK_RESET;
         busy_reg <= 1'b0;
         core_stall_reg <= 1'b0;
         irq_block_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         lock_reg <= lock_next;
         busy_reg <= busy_next;
         core_stall_reg <= (state_next == FSAPG_PROG_STALL_REGION);
         irq_block_reg <= irq_block_next;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spm_accept_reg <= 1'b0;
         spm_refused_reg <= 1'b0;
         prog_start_reg <= 1'b0;
         prog_erase_reg <= 1'b0;
         prog_page_reg <= '0;
         lpm_grant_reg <= 1'b0;
         lpm_deny_reg <= 1'b0;
      end else begin
         spm_accept_reg <= spm_go;
         spm_refused_reg <= spm_bad;
         prog_start_reg <= prog_go;
         if (prog_go) begin
            prog_erase_reg <= (spm_op == fsapg_pkg::OP_ERASE);
            prog_page_reg <= spm_addr;
         end
         lpm_grant_reg <= lpm_req && lpm_ok;
         lpm_deny_reg <= lpm_req && !lpm_ok;
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = readdata_reg;
   assign spm_accept = spm_accept_reg;
   assign spm_refused = spm_refused_reg;
   assign prog_start = prog_start_reg;
   assign prog_erase = prog_erase_reg;
   assign prog_page = prog_page_reg;
   assign core_stall = core_stall_reg;
   assign region_busy_flag = busy_reg;
   assign lpm_grant = lpm_grant_reg;
   assign lpm_deny = lpm_deny_reg;
   assign irq_block = irq_block_reg;

   default clocking fsapg_cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence seq_stall_region_start;
      prog_go && !spm_tgt_rww;
   endsequence
   sequence seq_stall_region_finish;
      (state_reg == FSAPG_PROG_STALL_REGION) && prog_done;
   endsequence

   AST_APP_SPM_IGNORED: assert property (spm_req && !spm_pc_in_boot |=> !prog_start_reg && !spm_accept_reg)
      else $error("store from application region was not ignored");
   AST_BOOT_ANY_PAGE: assert property (spm_req && spm_op == fsapg_pkg::OP_WRITE && spm_pc_in_boot && idle
         && lock_reg == fsapg_pkg::LOCK_RESET |=> prog_start_reg && prog_page_reg == $past(spm_addr))
      else $error("unlocked boot store did not start on its page");
   AST_BOOT_SPLIT: assert property (spm_pc_in_boot == (core_pc >= fsapg_pkg::fsapg_boot_start(fuse_reg)))
      else $error("boot split does not follow the size fuses");
   AST_FIXED_SPLIT: assert property (spm_tgt_rww == (spm_addr < fsapg_pkg::STALL_REGION_START))
      else $error("stall split is not at the fixed boundary");
   AST_RWW_RUNS: assert property (state_reg == FSAPG_PROG_RWW |-> !core_stall_reg && busy_reg)
      else $error("core stalled or busy clear during concurrent-read programming");
   AST_STALL_REGION_ENTER: assert property (seq_stall_region_start |=> core_stall_reg && prog_start_reg)
      else $error("stall-region programming did not halt the core");
   AST_STALL_REGION_HOLD: assert property ((state_reg == FSAPG_PROG_STALL_REGION) && !prog_done |=> core_stall_reg)
      else $error("core released before stall-region programming ended");
   AST_STALL_REGION_RELEASE: assert property (seq_stall_region_finish |=> !core_stall_reg ##1 !core_stall_reg)
      else $error("core still halted after programming ended");
   AST_BUSY_BLOCKS: assert property (lpm_req && busy_reg && lpm_tgt_rww |=> lpm_deny_reg && !lpm_grant_reg)
      else $error("load of blocked region was granted");
   AST_BUSY_HOLDS: assert property (busy_reg && !busy_clr |=> busy_reg)
      else $error("busy flag dropped without a clear");
   AST_BOOT_IN_STALL: assert property (fsapg_pkg::fsapg_boot_start(fuse_reg) >= fsapg_pkg::STALL_REGION_START)
      else $error("boot region reaches into concurrent-read region");
   AST_LOCK_ONE_WAY: assert property (!chip_erase |=> (lock_reg & ~$past(lock_reg)) == '0)
      else $error("lock bit returned to one without chip erase");
   AST_LOCK_ERASE: assert property (chip_erase |=> lock_reg == fsapg_pkg::LOCK_RESET)
      else $error("chip erase did not clear lock bits");
   AST_APP_WRITE_LOCK: assert property (spm_req && is_prog_op && !spm_tgt_boot
         && !lock_reg[fsapg_pkg::LOCK_APP_LO] |=> spm_refused_reg && !prog_start_reg)
      else $error("store into locked application region started");
   AST_BOOT_WRITE_LOCK: assert property (spm_req && is_prog_op && spm_tgt_boot
         && !lock_reg[fsapg_pkg::LOCK_BOOT_LO] |=> spm_refused_reg && !prog_start_reg)
      else $error("store into locked boot region started");
   AST_APP_READ_LOCK: assert property (lpm_req && spm_pc_in_boot && !lpm_tgt_boot
         && !lock_reg[fsapg_pkg::LOCK_APP_HI] |=> lpm_deny_reg)
      else $error("boot load of locked application region granted");
   AST_BOOT_READ_LOCK: assert property (lpm_req && !spm_pc_in_boot && lpm_tgt_boot
         && !lock_reg[fsapg_pkg::LOCK_BOOT_HI] |=> lpm_deny_reg)
      else $error("application load of locked boot region granted");
   AST_IRQ_APP: assert property (!lock_reg[fsapg_pkg::LOCK_APP_HI] && ivec_in_boot && !spm_pc_in_boot
         |=> irq_block_reg)
      else $error("interrupts left enabled in locked application code");
   AST_IRQ_BOOT: assert property (!lock_reg[fsapg_pkg::LOCK_BOOT_HI] && !ivec_in_boot && spm_pc_in_boot
         |=> irq_block_reg)
      else $error("interrupts left enabled in locked boot code");
   AST_FREE_REGION: assert property (lpm_req && lock_reg == fsapg_pkg::LOCK_RESET && !(busy_reg && lpm_tgt_rww)
         |=> lpm_grant_reg)
      else $error("load refused with all locks unprogrammed");
   AST_BUSY_CLEAR: assert property (busy_reg && busy_clr && !busy_set |=> !region_busy_flag)
      else $error("busy flag not cleared");
   AST_REFUSE_QUIET: assert property (spm_bad && idle |=> !prog_start_reg && !core_stall_reg
         && state_reg == FSAPG_IDLE && !spm_accept_reg)
      else $error("refused store had an effect");
   AST_BUS_ANSWER: assert property (bus_req && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");
   // Every store gets exactly one answer pulse
   AST_STORE_ONE_ANSWER: assert property (spm_req |=> spm_accept_reg != spm_refused_reg)
      else $error("store answered twice or not at all");
   AST_LOAD_ONE_ANSWER: assert property (lpm_req |=> lpm_grant_reg != lpm_deny_reg)
      else $error("load answered twice or not at all");
   AST_BUSY_SET: assert property (prog_go && spm_tgt_rww |=> region_busy_flag && !core_stall_reg)
      else $error("concurrent-read programming did not set busy");
   // A stall without a running erase or write would hang the core
   AST_STALL_ONLY_PROG: assert property (core_stall_reg |-> state_reg == FSAPG_PROG_STALL_REGION)
      else $error("core halted outside stall-region programming");
endmodule
`default_nettype wire

// file: core/fsapg_pkg.sv
// Shared constants and types for the flash self-program access guard
package fsapg_pkg;
   localparam int ADDR_W = 16;
   localparam int AV_ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int LOCK_W = 4;
   localparam int FUSE_W = 2;

   // Fixed split: everything at or above this word address stalls the core
   localparam logic [ADDR_W-1:0] STALL_REGION_START = 16'hf000;

   // Boot region start per fuse code; largest region first
   localparam logic [FUSE_W-1:0] BOOT_SIZE_4K = 2'h0;
   localparam logic [FUSE_W-1:0] BOOT_SIZE_2K = 2'h1;
   localparam logic [FUSE_W-1:0] BOOT_SIZE_1K = 2'h2;
   localparam logic [FUSE_W-1:0] BOOT_SIZE_512 = 2'h3;
   localparam logic [ADDR_W-1:0] BOOT_START_4K = 16'hf000;
   localparam logic [ADDR_W-1:0] BOOT_START_2K = 16'hf800;
   localparam logic [ADDR_W-1:0] BOOT_START_1K = 16'hfc00;
   localparam logic [ADDR_W-1:0] BOOT_START_512 = 16'hfe00;
   // Safest assumption until the fuses are captured
   localparam logic [FUSE_W-1:0] FUSE_RESET = 2'h0;

   // Lock bit positions; 1 = unprogrammed, 0 = programmed
   localparam int LOCK_APP_LO = 0;
   localparam int LOCK_APP_HI = 1;
   localparam int LOCK_BOOT_LO = 2;
   localparam int LOCK_BOOT_HI = 3;
   localparam logic [LOCK_W-1:0] LOCK_RESET = 4'hf;

   // Register byte offsets
   localparam logic [AV_ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [AV_ADDR_W-1:0] REG_LOCK = 4'h4;
   localparam logic [AV_ADDR_W-1:0] REG_STAT = 4'h8;

   // Field positions
   localparam int CTRL_SPE_BIT = 0;
   localparam int CTRL_RRE_BIT = 4;
   localparam int CTRL_BUSY_BIT = 6;
   localparam int STAT_STALL_BIT = 0;
   localparam int STAT_IRQB_BIT = 1;
   localparam int STAT_FUSE_LSB = 8;

   typedef enum logic [1:0] {OP_LOAD, OP_ERASE, OP_WRITE, OP_LOCKSET} fsapg_op_t;

   function automatic logic [ADDR_W-1:0] fsapg_boot_start(input logic [FUSE_W-1:0] size);
      logic [ADDR_W-1:0] start;
      start = BOOT_START_4K;
      unique case (size)
         BOOT_SIZE_4K: start = BOOT_START_4K;
         BOOT_SIZE_2K: start = BOOT_START_2K;
         BOOT_SIZE_1K: start = BOOT_START_1K;
         BOOT_SIZE_512: start = BOOT_START_512;
      endcase
      return start;
   endfunction
endpackage

// file: core/fsapg_guard.sv
// Region decode and lock-bit permission check for one flash access
`timescale 1ns/10ps
`default_nettype none
module fsapg_guard (
   input wire logic [fsapg_pkg::FUSE_W-1:0] boot_size,
   input wire logic [fsapg_pkg::ADDR_W-1:0] pc,
   input wire logic [fsapg_pkg::ADDR_W-1:0] target,
   input wire logic [fsapg_pkg::LOCK_W-1:0] lock,
   output logic pc_in_boot,
   output logic tgt_in_boot,
   output logic tgt_in_rww,
   output logic store_ok,
   output logic load_ok
);
   function automatic logic in_boot(input logic [fsapg_pkg::ADDR_W-1:0] a,
                                    input logic [fsapg_pkg::FUSE_W-1:0] s);
      return a >= fsapg_pkg::fsapg_boot_start(s);
   endfunction

   assign pc_in_boot = in_boot(pc, boot_size);
   assign tgt_in_boot = in_boot(target, boot_size);
   assign tgt_in_rww = target < fsapg_pkg::STALL_REGION_START;

   // The general memory lock has no input here: it never gates core accesses
   assign store_ok = pc_in_boot && (tgt_in_boot ? lock[fsapg_pkg::LOCK_BOOT_LO]
                                                : lock[fsapg_pkg::LOCK_APP_LO]);
   // Same-region reads are never restricted by the lock bits
   assign load_ok = (pc_in_boot && !tgt_in_boot) ? lock[fsapg_pkg::LOCK_APP_HI] :
                    (!pc_in_boot && tgt_in_boot) ? lock[fsapg_pkg::LOCK_BOOT_HI] :
                    1'b1;
endmodule
`default_nettype wire

// file: verif/fsapg_core_model.sv
// Processor core and flash timing model facing the guard
`timescale 1ns/10ps
`default_nettype none
module fsapg_core_model (
   input wire logic clk,
   input wire logic prog_start,
   output logic prog_done = 1'b0,
   output logic [15:0] core_pc = 16'h0,
   output logic spm_req = 1'b0,
   output fsapg_pkg::fsapg_op_t spm_op = fsapg_pkg::OP_LOAD,
   output logic [15:0] spm_addr = 16'h0,
   output logic [3:0] spm_lock_data = 4'hf,
   output logic lpm_req = 1'b0,
   output logic [15:0] lpm_addr = 16'h0
);
   int prog_lat = 12;
   int cnt = 0;
   // Flash ends each erase or write prog_lat cycles after its start
   always @(posedge clk) begin
      prog_done <= (cnt == 1);
      if (prog_start === 1'b1)
         cnt <= prog_lat;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // No interrupt fetches are modelled, so none can hit a blocked region
   task automatic at(input logic [15:0] pc);
      core_pc <= pc;
      @(posedge clk);
   endtask
   // Address inverted once released so a stale value is never reused
   task automatic store(input fsapg_pkg::fsapg_op_t op, input logic [15:0] a, input logic [3:0] d);
      spm_req <= 1'b1;
      spm_op <= op;
      spm_addr <= a;
      spm_lock_data <= d;
      @(posedge clk);
      spm_req <= 1'b0;
      spm_addr <= ~a;
      @(posedge clk);
   endtask
   task automatic load(input logic [15:0] a);
      lpm_req <= 1'b1;
      lpm_addr <= a;
      @(posedge clk);
      lpm_req <= 1'b0;
      lpm_addr <= ~a;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: verif/fsapg_top_tb.sv
// Self-checking bench for the flash self-program access guard
`timescale 1ns/10ps
`default_nettype none
module fsapg_top_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic chip_erase = 1'b0;
   logic ext_lock_wr = 1'b0;
   logic ivec_in_boot = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [3:0] ext_lock_data = 4'hf;
   logic [31:0] avs_writedata = 32'h0;
   logic [1:0] boot_size_fuses = 2'h0;
   logic [1:0] f;
   logic [31:0] avs_readdata, rd;
   logic [15:0] core_pc, spm_addr, lpm_addr, prog_page, bs, app;
   logic [3:0] spm_lock_data, v;
   fsapg_pkg::fsapg_op_t spm_op;
   logic avs_waitrequest, spm_req, lpm_req, prog_done, spm_accept, spm_refused, prog_start, prog_erase;
   logic core_stall, region_busy_flag, lpm_grant, lpm_deny, irq_block;
   int n_errors = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   fsapg_top dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .boot_size_fuses(boot_size_fuses),
      .chip_erase(chip_erase), .ext_lock_wr(ext_lock_wr), .ext_lock_data(ext_lock_data), .core_pc(core_pc),
      .ivec_in_boot(ivec_in_boot), .spm_req(spm_req), .spm_op(spm_op), .spm_addr(spm_addr),
      .spm_lock_data(spm_lock_data), .lpm_req(lpm_req), .lpm_addr(lpm_addr), .prog_done(prog_done),
      .spm_accept(spm_accept), .spm_refused(spm_refused), .prog_start(prog_start), .prog_erase(prog_erase),
      .prog_page(prog_page), .core_stall(core_stall), .region_busy_flag(region_busy_flag),
      .lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .irq_block(irq_block));
   fsapg_core_model core (.clk(clk), .prog_start(prog_start), .prog_done(prog_done), .core_pc(core_pc),
      .spm_req(spm_req), .spm_op(spm_op), .spm_addr(spm_addr), .spm_lock_data(spm_lock_data),
      .lpm_req(lpm_req), .lpm_addr(lpm_addr));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Request held until waitrequest is seen low; data taken at that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ld(input logic [15:0] a, input logic ok);
      core.load(a);
      check("lpm_grant", lpm_grant, ok);
      check("lpm_deny", lpm_deny, !ok);
   endtask
   task automatic st(input fsapg_pkg::fsapg_op_t op, input logic [15:0] a, input logic ok);
      logic prog;
      logic concurrent_read_region;
      prog = ok && (op == fsapg_pkg::OP_ERASE || op == fsapg_pkg::OP_WRITE);
      concurrent_read_region = a < 16'hf000;
      core.store(op, a, v);
      check("spm_accept", spm_accept, ok);
      check("spm_refused", spm_refused, !ok);
      check("prog_start", prog_start, prog);
      check("core_stall", core_stall, prog && !concurrent_read_region);
      if (prog) begin
         check("prog_page", prog_page, a);
         check("prog_erase", prog_erase, op == fsapg_pkg::OP_ERASE);
         check("region_busy_flag", region_busy_flag, concurrent_read_region);
         if (concurrent_read_region) begin
            ld(a, 1'b0);
            ld(bs, 1'b1);
            core.store(fsapg_pkg::OP_WRITE, bs, v);
            check("spm_refused", spm_refused, 1'b1);
         end
         for (int n = 0; n < 60; n++) begin
            bus(1'b0, fsapg_pkg::REG_CTRL, 32'h0);
            if (rd[0] === 1'b0)
               break;
         end
         check("core_stall", core_stall, 1'b0);
         check("ctrl_busy", rd[6], concurrent_read_region);
         if (concurrent_read_region) begin
            // Busy must be cleared before the region is touched again
            if (a[0])
               bus(1'b1, fsapg_pkg::REG_CTRL, 32'h11);
            else
               core.store(fsapg_pkg::OP_LOAD, a, v);
            @(posedge clk);
            check("region_busy_flag", region_busy_flag, 1'b0);
         end
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   initial begin
      rd = $urandom(32'h4704f23c);
      f = 2'($urandom_range(3));
      boot_size_fuses = f;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      bs = 16'hffff << (12 - int'(f));
      // Fuses are sampled once, so a late change must not show
      boot_size_fuses <= ~f;
      bus(1'b0, fsapg_pkg::REG_STAT, 32'h0);
      check("fuse_code", rd[9:8], f);
      avs_byteenable <= 4'he;
      bus(1'b1, fsapg_pkg::REG_LOCK, 32'h0);
      avs_byteenable <= 4'hf;
      bus(1'b0, 4'hc, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b0, fsapg_pkg::REG_LOCK, 32'h0);
      check("lock_reset", rd, 32'hf);
      $display("registers done");
      app = 16'($urandom_range(16'hefff));
      core.at(app);
      st(fsapg_pkg::OP_ERASE, app, 1'b0);
      $display("application store done");
      for (int i = 0; i < 8; i++) begin
         v = (i < 2) ? {4{i[0]}} : 4'($urandom);
         core.prog_lat = 10 + $urandom_range(20);
         app = 16'($urandom_range(16'hefff));
         chip_erase <= 1'b1;
         @(posedge clk);
         chip_erase <= 1'b0;
         ext_lock_wr <= 1'b1;
         ext_lock_data <= {v[3:2], 2'b11};
         @(posedge clk);
         ext_lock_wr <= 1'b0;
         bus(1'b1, fsapg_pkg::REG_LOCK, {28'h0, 2'b11, v[1:0]});
         bus(1'b1, fsapg_pkg::REG_LOCK, 32'hf);
         bus(1'b0, fsapg_pkg::REG_LOCK, 32'h0);
         check("lock", rd, {28'h0, v});
         ivec_in_boot <= 1'b1;
         core.at(app);
         @(posedge clk);
         check("irq_block", irq_block, !v[1]);
         ld(bs, v[3]);
         ivec_in_boot <= 1'b0;
         core.at(bs);
         @(posedge clk);
         check("irq_block", irq_block, !v[3]);
         ld(app, v[1]);
         st(fsapg_pkg::OP_LOCKSET, 16'h0, 1'b1);
         st(fsapg_pkg::OP_ERASE, app, v[0]);
         st(fsapg_pkg::OP_WRITE, bs | 16'($urandom_range(511)), v[2]);
         st(fsapg_pkg::OP_ERASE, 16'hf000, (bs == 16'hf000) ? v[2] : v[0]);
         $display("lock pattern %h done", v);
      end
      complete_run();
   end
endmodule
`default_nettype wire
